// ---- verilog/watchdog_and_option_latches.sv ----
// Overview of operation
// R1: option registers accept only first write after reset
// R2: reset restores option defaults except supply mode
// R3: supply mode cleared only at power-on, once-writable
// R4: option registers at fixed indices, always readable
// R5: timebase select inserts divide-by-128 prescaler
// R6: oscillator keeps running in stop when enabled
// R7: baud source picks bus or oscillator clock
// R8: rate bit picks short or long timeout
// R9: monitor stays on in stop if enabled
// R10: reset-disable blocks monitor reset; power-down disables
// R11: supply mode bit selects 5-V or 3-V
// R12: stop exit waits 32 or 4096 cycles
// R13: monitor-reset stop exit always uses long delay
// R14: software avoids short recovery with stopped oscillator
// R15: disabled stop instruction raises illegal opcode reset
// R16: disable bit holds the watchdog inactive
// R17: 6-bit counter behind 12-bit prescaler resets chip
// R18: service write clears counter and prescaler stages; the low 4 prescaler bits are kept
// R19: service read returns reset vector low byte
// R20: watchdog reset drives pin 32 cycles, flags
// R21: stop, vector fetch, internal reset clear chain; stop and vector fetch clear only the 12-bit prescaler
// R22: monitor mode test voltage or blank vectors disable
// R23: per-register written flag blocks later writes
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.svh"
module watchdog_and_option_latches #(
  parameter int LONG_TIMEOUT = `WD_LONG_TIMEOUT,
  parameter int SHORT_TIMEOUT = `WD_SHORT_TIMEOUT,
  parameter int REC_LONG = `WD_REC_LONG
) (
  input wire logic ref_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side events, same clock
  input wire logic stopInstr,
  input wire logic wakeEvent,
  input wire logic vectorFetch,
  input wire logic otherResetReq,
  input wire logic [7:0] resetVectorLow,
  input wire logic monitorMode,
  input wire logic blankVectors,
  input wire logic busClockTick,
  input wire logic oscClockTick,
  // asynchronous pin levels
  input wire logic testVoltagePin,
  input wire logic lviTripPin,
  // outputs
  output logic stopMode,
  output logic recoveryBusy,
  output logic illegalOpcodeReset,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic watchdogResetFlag,
  output logic oscillatorRun,
  output logic monitorEnable,
  output logic monitorResetOut,
  output logic supplyFiveVolt,
  output logic timebaseTick,
  output logic serialClockTick,
  output logic serialSourceInternal
);
  // ==========================================================
  // address decode
  localparam int CW = `WD_CHAIN_W;
  localparam int KW = `WD_SVC_KEEP_W;
  localparam int PW = `WD_PRESCALE_W;
  wire logic upperZero = (paddr[31:18] == 14'h0000); // no alias above the map
  wire logic selOptOne = upperZero & (paddr[17:0] == `WD_ADDR_OPT_ONE); // [R4]
  wire logic selOptTwo = upperZero & (paddr[17:0] == `WD_ADDR_OPT_TWO); // [R4]
  wire logic selService = upperZero & (paddr[17:0] == `WD_ADDR_SERVICE);
  wire logic selStatus = upperZero & (paddr[17:0] == `WD_ADDR_STATUS);
  wire logic selAny = selOptOne | selOptTwo | selService | selStatus;
  wire logic setupPhase = psel & ~penable; // read data is captured here
  wire logic accessPhase = psel & penable; // zero wait access
  wire logic busWrite = accessPhase & pwrite & selAny;
  wire logic writeOptOne = busWrite & selOptOne;
  wire logic writeOptTwo = busWrite & selOptTwo;
  wire logic serviceWrite = busWrite & selService; // any value services
  // ==========================================================
  // pin synchronisers
  logic tvMeta_q; // first stage, read only by the second
  logic tvSync_q; // test high voltage present
  logic lviMeta_q; // first stage, read only by the second
  logic lviSync_q; // monitor trip level
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tvMeta_q <= 1'b0;
      tvSync_q <= 1'b0;
      lviMeta_q <= 1'b0;
      lviSync_q <= 1'b0;
    end else begin
      tvMeta_q <= testVoltagePin;
      tvSync_q <= tvMeta_q;
      lviMeta_q <= lviTripPin;
      lviSync_q <= lviMeta_q;
    end
  end
  // ==========================================================
  // option latches
  logic [7:0] optOneRaw; // first register bits
  logic [7:0] optTwoRaw; // second register bits
  logic optOneWritten; // first register locked
  logic optTwoWritten; // second register locked
  wdog_pkg::opt_one_t optOne; // first register fields
  wdog_pkg::opt_two_t optTwo; // second register fields
  logic internalReset; // any reset other than power-on
  assign optOne = wdog_pkg::opt_one_t'(optOneRaw);
  assign optTwo = wdog_pkg::opt_two_t'(optTwoRaw);
  // first register, supply mode bit kept over ordinary resets
  option_latch #(
    .WIDTH(8),
    .RESET_VALUE(`WD_OPT_ONE_RESET),
    .KEEP_MASK(`WD_OPT_ONE_KEEP),
    .USED_MASK(`WD_OPT_ONE_USED)
  ) u_opt_one (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .softReset(internalReset), // [R2]
    .writeStrobe(writeOptOne), // [R1]
    .writeData(pwdata[7:0]),
    .value(optOneRaw),
    .written(optOneWritten)
  );
  // second register, baud source defaults to bus clock
  option_latch #(
    .WIDTH(8),
    .RESET_VALUE(`WD_OPT_TWO_RESET),
    .KEEP_MASK(`WD_OPT_TWO_KEEP),
    .USED_MASK(`WD_OPT_TWO_USED)
  ) u_opt_two (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .softReset(internalReset), // [R2]
    .writeStrobe(writeOptTwo), // [R1]
    .writeData(pwdata[7:0]),
    .value(optTwoRaw),
    .written(optTwoWritten)
  );
  // ==========================================================
  // stop mode sequencing
  wdog_pkg::stop_state_t state_q; // current stop phase
  wdog_pkg::stop_state_t state_d; // next stop phase
  logic illegal_q; // illegal opcode reset pulse
  logic recStart; // begin exit delay
  logic recLong; // exit delay is the long one
  logic recDone; // exit delay finished
  logic recBusy; // exit delay running
  logic lviResetEvt; // monitor reset asserted
  wire logic stopTaken = stopInstr & optOne.stopInstructionEnable & (state_q == wdog_pkg::ST_RUN);
  wire logic stopRefused = stopInstr & ~optOne.stopInstructionEnable; // [R15]
  wire logic inStop = (state_q == wdog_pkg::ST_STOPPED);
  wire logic stopExit = inStop & (wakeEvent | lviResetEvt);
  assign recStart = stopExit;
  assign recLong = lviResetEvt | ~optOne.shortStopRecovery; // [R12] [R13]
  // next state selection
  always_comb begin
    state_d = state_q;
    case (state_q)
      wdog_pkg::ST_RUN: begin
        // stop only when the instruction is enabled
        if (stopTaken) begin
          state_d = wdog_pkg::ST_STOPPED;
        end
      end
      wdog_pkg::ST_STOPPED: begin
        // interrupt or monitor reset wakes the part
        if (stopExit) begin
          state_d = wdog_pkg::ST_RECOVER;
        end
      end
      wdog_pkg::ST_RECOVER: begin
        // clocks usable after the delay
        if (recDone) begin
          state_d = wdog_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = wdog_pkg::ST_RUN;
      end
    endcase
  end
  // state register and illegal opcode pulse
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= wdog_pkg::ST_RUN;
      illegal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      illegal_q <= stopRefused; // [R15]
    end
  end
  // exit delay counter
  stop_recovery #(
    .SHORT_CYCLES(`WD_REC_SHORT),
    .LONG_CYCLES(REC_LONG)
  ) u_recovery (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(recStart),
    .useLong(recLong), // [R13]
    .busy(recBusy),
    .done(recDone)
  );
  // ==========================================================
  // low-voltage monitor and oscillator controls
  assign monitorEnable = ~optOne.voltageMonitorPowerDown
    & (~inStop | optOne.voltageMonitorInStop); // [R9] [R10]
  assign lviResetEvt = lviSync_q & monitorEnable & ~optOne.voltageMonitorResetDisable; // [R10]
  assign monitorResetOut = lviResetEvt;
  assign supplyFiveVolt = optOne.voltageMonitorSupplyMode; // [R11]
  assign oscillatorRun = ~inStop | optTwo.oscillatorInStopEnable; // [R6]
  assign stopMode = inStop;
  assign recoveryBusy = recBusy;
  assign illegalOpcodeReset = illegal_q;
  // ==========================================================
  // timebase prescaler and serial clock source
  logic [6:0] tbDiv_q; // divide-by-128 stage
  logic timebaseTick_q; // timebase clock enable
  logic serialClockTick_q; // serial clock enable
  wire logic tbWrap = (tbDiv_q == 7'(`WD_TB_DIV - 1));
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tbDiv_q <= 7'h00;
      timebaseTick_q <= 1'b0;
      serialClockTick_q <= 1'b0;
    end else begin
      // divider only advances while the oscillator runs
      if (oscillatorRun) begin
        tbDiv_q <= tbDiv_q + 7'h01;
      end
      timebaseTick_q <= oscillatorRun & (optTwo.timebaseExtraDividerSelect ? tbWrap : 1'b1); // [R5]
      serialClockTick_q <= optTwo.serialBaudClockSource ? busClockTick : oscClockTick; // [R7]
    end
  end
  assign timebaseTick = timebaseTick_q;
  assign serialClockTick = serialClockTick_q;
  assign serialSourceInternal = optTwo.serialBaudClockSource; // [R7]
  // ==========================================================
  // watchdog chain: prescaler low, counter high
  logic [CW-1:0] chain_q; // counter and prescaler as one
  logic blankLatch_q; // blank-vector monitor entry seen
  logic [5:0] pinCount_q; // reset pin low cycles left
  logic flag_q; // watchdog reset seen since power-on
  wire logic monitorBlock = (monitorMode & tvSync_q) | blankLatch_q; // [R22]
  wire logic watchdogActive = ~optOne.watchdogDisable & ~monitorBlock & ~inStop; // [R16] [R21]
  wire logic [CW-1:0] limit = optOne.watchdogRateSelect
    ? CW'(SHORT_TIMEOUT - 1) : CW'(LONG_TIMEOUT - 1); // [R8]
  wire logic wdogFire = watchdogActive & (chain_q >= limit) & ~internalReset; // [R17]
  wire logic pinDriving = (pinCount_q != 6'h00);
  assign internalReset = pinDriving | illegal_q | lviResetEvt | otherResetReq;
  // blank-vector disable holds until power-on
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      blankLatch_q <= 1'b0;
    end else if (monitorMode && blankVectors) begin
      blankLatch_q <= 1'b1; // [R22]
    end
  end
  // chain counting and clearing
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      chain_q <= '0;
    end else if (internalReset || wdogFire) begin
      chain_q <= '0; // [R21]
    end else if (serviceWrite) begin
      chain_q <= {{(CW-KW){1'b0}}, chain_q[KW-1:0]}; // [R18]
    end else if (stopTaken || vectorFetch) begin
      chain_q <= {chain_q[CW-1:PW], {PW{1'b0}}}; // [R21]
    end else if (watchdogActive) begin
      chain_q <= chain_q + CW'(1); // [R17]
    end
  end
  // reset pin pulse and sticky flag, set wins
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pinCount_q <= 6'h00;
      flag_q <= 1'b0;
    end else begin
      if (wdogFire) begin
        pinCount_q <= 6'(`WD_PIN_PULSE); // [R20]
      end else if (pinDriving) begin
        pinCount_q <= pinCount_q - 6'h01;
      end
      if (wdogFire) begin
        flag_q <= 1'b1; // [R20]
      end
    end
  end
  assign resetPinOut = 1'b0;
  assign resetPinOe = pinDriving; // [R20]
  assign watchdogResetFlag = flag_q;
  // ==========================================================
  // apb read data and answer
  logic [31:0] prdata_q; // data captured in setup cycle
  logic [7:0] statusByte; // block state view
  logic [7:0] readByte; // selected read value
  assign statusByte = {5'h00, optTwoWritten, optOneWritten, flag_q};
  assign readByte = selOptOne ? optOneRaw // [R4]
    : selOptTwo ? optTwoRaw
    : selService ? resetVectorLow // [R19]
    : selStatus ? statusByte
    : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prdata_q <= 32'h00000000;
    end else if (setupPhase && !pwrite) begin
      prdata_q <= {24'h000000, readByte};
    end
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~selAny;
endmodule : watchdog_and_option_latches
`default_nettype wire

// ---- verilog/wdog_map.svh ----
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH
// ==========================================================
// register indices (word index; byte address is index times four)
`define WD_IDX_OPT_TWO 16'h001E
`define WD_IDX_OPT_ONE 16'h001F
`define WD_IDX_SERVICE 16'hFFFF
`define WD_IDX_STATUS 16'h0020
`define WD_ADDR_OPT_TWO {`WD_IDX_OPT_TWO, 2'b00}
`define WD_ADDR_OPT_ONE {`WD_IDX_OPT_ONE, 2'b00}
`define WD_ADDR_SERVICE {`WD_IDX_SERVICE, 2'b00}
`define WD_ADDR_STATUS {`WD_IDX_STATUS, 2'b00}
// ==========================================================
// reset values and masks of the option latches
`define WD_OPT_ONE_RESET 8'h00
`define WD_OPT_TWO_RESET 8'h01
`define WD_OPT_ONE_KEEP 8'h08
`define WD_OPT_TWO_KEEP 8'h00
`define WD_OPT_ONE_USED 8'hFF
`define WD_OPT_TWO_USED 8'h07
// ==========================================================
// status register field positions
`define WD_STAT_FLAG_BIT 0
`define WD_STAT_ONE_WR_BIT 1
`define WD_STAT_TWO_WR_BIT 2
// ==========================================================
// timing counts in crystal clock cycles, then watchdog chain field widths in bits
`define WD_LONG_TIMEOUT ((1 << 18) - (1 << 4))
`define WD_SHORT_TIMEOUT ((1 << 13) - (1 << 4))
`define WD_PIN_PULSE 32
`define WD_REC_SHORT 32
`define WD_REC_LONG 4096
`define WD_TB_DIV 128
`define WD_CHAIN_W 18
`define WD_SVC_KEEP_W 4
`define WD_PRESCALE_W 12
`endif

// ---- verilog/wdog_pkg.sv ----
// ==========================================================
// types shared by the watchdog and option latch files
package wdog_pkg;
  // first option register layout, msb first
  typedef struct packed {
    logic watchdogRateSelect;
    logic voltageMonitorInStop;
    logic voltageMonitorResetDisable;
    logic voltageMonitorPowerDown;
    logic voltageMonitorSupplyMode;
    logic shortStopRecovery;
    logic stopInstructionEnable;
    logic watchdogDisable;
  } opt_one_t;
  // second option register layout, msb first
  typedef struct packed {
    logic [4:0] unused;
    logic timebaseExtraDividerSelect;
    logic oscillatorInStopEnable;
    logic serialBaudClockSource;
  } opt_two_t;
  // stop mode sequencing states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOPPED = 2'b01,
    ST_RECOVER = 2'b10
  } stop_state_t;
endpackage : wdog_pkg

// ---- verilog/option_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// write-once option latch
module option_latch #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] KEEP_MASK = '0,
  parameter logic [WIDTH-1:0] USED_MASK = '1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic softReset,
  input wire logic writeStrobe,
  input wire logic [WIDTH-1:0] writeData,
  output logic [WIDTH-1:0] value,
  output logic written
);
  logic [WIDTH-1:0] value_q; // stored settings
  logic written_q; // ordinary bits already written since any reset
  logic keepWritten_q; // kept bits already written since power-on
  wire logic takeOrdinary = writeStrobe & ~written_q & ~softReset; // [R1] [R23]
  wire logic takeKeep = writeStrobe & ~keepWritten_q & ~softReset; // [R3]
  wire logic [WIDTH-1:0] ordMask = ~KEEP_MASK & USED_MASK;
  wire logic [WIDTH-1:0] keepMask = KEEP_MASK & USED_MASK;
  // ==========================================================
  // latch update
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      value_q <= RESET_VALUE & USED_MASK;
      written_q <= 1'b0;
      keepWritten_q <= 1'b0;
    end else begin
      // ordinary reset restores defaults but spares kept bits
      if (softReset) begin
        value_q <= (value_q & keepMask) | (RESET_VALUE & ordMask); // [R2] [R3]
        written_q <= 1'b0;
      end else begin
        // each part takes only its first write; later ones dropped silently
        value_q <= ((takeOrdinary ? writeData : value_q) & ordMask)
          | ((takeKeep ? writeData : value_q) & keepMask); // [R1] [R3]
        written_q <= written_q | takeOrdinary; // [R23]
        keepWritten_q <= keepWritten_q | takeKeep; // [R3]
      end
    end
  end
  assign value = value_q;
  assign written = written_q;
endmodule : option_latch
`default_nettype wire

// ---- verilog/stop_recovery.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// stop exit delay counter
module stop_recovery #(
  parameter int SHORT_CYCLES = 32,
  parameter int LONG_CYCLES = 4096
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic useLong,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(LONG_CYCLES) + 1;
  logic [CW-1:0] count_q; // cycles still to wait
  logic busy_q; // delay running
  logic done_q; // one-cycle end marker
  // ==========================================================
  // countdown
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      // load long or short delay
      count_q <= useLong ? CW'(LONG_CYCLES - 1) : CW'(SHORT_CYCLES - 1); // [R12] [R13]
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q) begin
      // last cycle of the delay ends it
      count_q <= count_q - CW'(1);
      busy_q <= (count_q != '0);
      done_q <= (count_q == '0);
    end else begin
      done_q <= 1'b0;
    end
  end
  assign busy = busy_q;
  assign done = done_q;
endmodule : stop_recovery
`default_nettype wire

// ---- bench/wdog_checker_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the watchdog and option latches
module wdog_checker #(
  parameter int REC_LONG = 4096
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic stopInstr,
  input wire logic busClockTick,
  input wire logic oscClockTick,
  input wire logic [7:0] resetVectorLow,
  input wire logic stopMode,
  input wire logic recoveryBusy,
  input wire logic illegalOpcodeReset,
  input wire logic resetPinOe,
  input wire logic watchdogResetFlag,
  input wire logic oscillatorRun,
  input wire logic serialClockTick,
  input wire logic serialSourceInternal
);
  logic [12:0] busyCnt_q; // recovery cycles so far
  logic [5:0] pinCnt_q; // pin drive cycles so far
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // run-length counters, cleared whenever the level drops
  always_ff @(posedge ref_clk) begin
    busyCnt_q <= (rstn && recoveryBusy) ? busyCnt_q + 13'h0001 : 13'h0000;
    pinCnt_q <= (rstn && resetPinOe) ? pinCnt_q + 6'h01 : 6'h00;
  end
  // ==========================================================
  // assertions
  pin_pulse_a: assert property ($fell(resetPinOe) |-> pinCnt_q == 6'h20)
    else $error("reset pin drive length wrong");
  flag_set_a: assert property ($rose(resetPinOe) |-> ##[0:1] watchdogResetFlag)
    else $error("watchdog flag not set on fire");
  osc_run_a: assert property (!stopMode |-> oscillatorRun)
    else $error("oscillator off outside stop");
  illegal_cause_a: assert property (illegalOpcodeReset |-> $past(stopInstr) && !stopMode)
    else $error("illegal opcode reset without refused stop");
  illegal_pulse_a: assert property (illegalOpcodeReset |=> !illegalOpcodeReset)
    else $error("illegal opcode reset too long");
  serial_src_a: assert property ($past(rstn) |-> serialClockTick ==
    ($past(serialSourceInternal) ? $past(busClockTick) : $past(oscClockTick)))
    else $error("serial clock from wrong source");
  rec_len_a: assert property ($fell(recoveryBusy) |->
    busyCnt_q == 13'h0020 || busyCnt_q == REC_LONG)
    else $error("stop recovery length wrong");
  unmapped_err_a: assert property (psel && penable && paddr == 32'h00000004 |-> pslverr)
    else $error("unmapped access without error");
  svc_read_a: assert property (psel && !penable && !pwrite && paddr == 32'h0003FFFC
    |=> prdata == {24'h000000, $past(resetVectorLow)})
    else $error("service read not vector low byte");
endmodule : wdog_checker
bind watchdog_and_option_latches wdog_checker #(.REC_LONG(REC_LONG)) i_chk (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .stopInstr(stopInstr),
  .busClockTick(busClockTick), .oscClockTick(oscClockTick), .resetVectorLow(resetVectorLow),
  .stopMode(stopMode), .recoveryBusy(recoveryBusy), .illegalOpcodeReset(illegalOpcodeReset),
  .resetPinOe(resetPinOe), .watchdogResetFlag(watchdogResetFlag), .oscillatorRun(oscillatorRun),
  .serialClockTick(serialClockTick), .serialSourceInternal(serialSourceInternal)
);
`default_nettype wire

// ---- bench/apb_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// cpu side apb master
module apb_cpu_model (
  input wire logic ref_clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
  end
  // one transfer: setup, access until pready, then release
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show a changed pattern, not the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_cpu_model
`default_nettype wire

// ---- bench/watchdog_and_option_latches_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.svh"
// ==========================================================
// testbench top
module watchdog_and_option_latches_tb;
  localparam int SHORT = 64; // shortened fast timeout
  localparam int REC = 64; // shortened long recovery
  localparam logic [31:0] A1 = {14'h0000, `WD_ADDR_OPT_ONE};
  localparam logic [31:0] A2 = {14'h0000, `WD_ADDR_OPT_TWO};
  localparam logic [31:0] AS = {14'h0000, `WD_ADDR_STATUS};
  localparam logic [31:0] AV = {14'h0000, `WD_ADDR_SERVICE};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, q;
  logic stopInstr = 1'b0, wakeEvent = 1'b0, otherResetReq = 1'b0, lviTripPin = 1'b0;
  logic busClockTick = 1'b0, oscClockTick = 1'b0;
  logic [7:0] resetVectorLow = 8'hA5;
  logic [3:0] cyc = 4'h0;
  logic stopMode, recoveryBusy, illegalOpcodeReset, resetPinOe, watchdogResetFlag;
  logic oscillatorRun, supplyFiveVolt, serialSourceInternal, timebaseTick;
  int err_total = 0;
  int checks = 0;
  always #5 ref_clk = ~ref_clk;
  // two unlike tick streams for the serial source select
  always @(posedge ref_clk) begin
    cyc <= cyc + 4'h1;
    busClockTick <= cyc[0];
    oscClockTick <= &cyc[1:0];
  end
  watchdog_and_option_latches #(.LONG_TIMEOUT(512), .SHORT_TIMEOUT(SHORT), .REC_LONG(REC)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stopInstr(stopInstr), .wakeEvent(wakeEvent), .vectorFetch(1'b0),
    .otherResetReq(otherResetReq), .resetVectorLow(resetVectorLow), .monitorMode(1'b0),
    .blankVectors(1'b0), .busClockTick(busClockTick), .oscClockTick(oscClockTick),
    .testVoltagePin(1'b0), .lviTripPin(lviTripPin), .stopMode(stopMode),
    .recoveryBusy(recoveryBusy), .illegalOpcodeReset(illegalOpcodeReset),
    .resetPinOut(), .resetPinOe(resetPinOe), .watchdogResetFlag(watchdogResetFlag),
    .oscillatorRun(oscillatorRun), .monitorEnable(), .monitorResetOut(),
    .supplyFiveVolt(supplyFiveVolt), .timebaseTick(timebaseTick), .serialClockTick(),
    .serialSourceInternal(serialSourceInternal));
  apb_cpu_model i_cpu (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_cpu.xfer(a, 1'b1, d, q, e);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    i_cpu.xfer(a, 1'b0, 32'h00000000, q, e);
    chk(q, exp);
  endtask : rd
  // one-cycle pulse on the other reset source
  task automatic intReset();
    @(posedge ref_clk);
    otherResetReq <= 1'b1;
    @(posedge ref_clk);
    otherResetReq <= 1'b0;
  endtask : intReset
  // stop, wake by interrupt or monitor trip, then count the recovery cycles
  task automatic stopCycle(input int n, input logic viaMonitor);
    int k = 0;
    @(posedge ref_clk);
    stopInstr <= 1'b1;
    @(posedge ref_clk);
    stopInstr <= 1'b0;
    @(negedge ref_clk);
    chk(stopMode, 32'h1);
    chk(oscillatorRun, 32'h1);
    @(posedge ref_clk);
    wakeEvent <= !viaMonitor;
    lviTripPin <= viaMonitor; // one-cycle trip pulse
    @(posedge ref_clk);
    {wakeEvent, lviTripPin} <= 2'b00;
    repeat (n + 20) begin
      @(negedge ref_clk);
      k += int'(recoveryBusy === 1'b1);
    end
    chk(k, n);
  endtask : stopCycle
  // ==========================================================
  // scenarios
  task automatic resetValues();
    rd(A1, 32'h00);
    rd(A2, 32'h01);
    rd(32'h4, 32'h00);
    chk(e, 32'h1);
  endtask : resetValues
  task automatic writeOnce();
    int k = 0;
    wr(A1, 32'h0B);
    wr(A1, 32'h00);
    rd(A1, 32'h0B);
    rd(AS, 32'h02);
    chk(supplyFiveVolt, 32'h1);
    wr(A2, 32'h06);
    wr(A2, 32'h01);
    rd(A2, 32'h06);
    chk(serialSourceInternal, 32'h0);
    repeat (128) begin
      @(negedge ref_clk);
      k += int'(timebaseTick === 1'b1);
    end
    chk(k, 1);
  endtask : writeOnce
  task automatic stopShort();
    intReset();
    rd(A1, 32'h08);
    rd(A2, 32'h01);
    wr(A2, 32'h02); // oscillator kept running so short recovery is safe
    wr(A1, 32'h07);
    rd(A1, 32'h0F);
    stopCycle(32, 1'b0);
  endtask : stopShort
  task automatic monitorWake();
    intReset();
    wr(A2, 32'h02); // oscillator kept running in stop
    wr(A1, 32'h47);
    stopCycle(REC, 1'b1);
    rd(A1, 32'h08);
  endtask : monitorWake
  task automatic illegalStop();
    intReset();
    @(posedge ref_clk);
    stopInstr <= 1'b1;
    @(posedge ref_clk);
    stopInstr <= 1'b0;
    @(negedge ref_clk);
    chk(illegalOpcodeReset, 32'h1);
    chk(stopMode, 32'h0);
    rd(A1, 32'h08);
  endtask : illegalStop
  task automatic watchdogRun();
    int k;
    wr(A1, 32'h88);
    repeat (3) begin
      wr(AV, 32'h00);
      repeat (40) @(negedge ref_clk);
      chk(resetPinOe, 32'h0);
    end
    rd(AV, 32'hA5);
    wr(AV, 32'h00);
    k = 0;
    while (resetPinOe !== 1'b1 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    chk(k >= SHORT - 17 && k <= SHORT + 2, 32'h1);
    k = 0;
    while (resetPinOe === 1'b1 && k < 100) begin
      @(negedge ref_clk);
      k++;
    end
    chk(k, 32);
    rd(AS, 32'h01);
  endtask : watchdogRun
  // ==========================================================
  // verdict and end of run
  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    resetValues();
    writeOnce();
    stopCycle(REC, 1'b0);
    stopShort();
    monitorWake();
    illegalStop();
    watchdogRun();
    summarize();
  end
  // hang guard
  initial begin
    #200000;
    err_total++;
    summarize();
  end
endmodule : watchdog_and_option_latches_tb
`default_nettype wire
